// File: core/rcd_pkg.sv
package rcd_pkg;
  // Register word offsets (byte addresses)
  localparam logic [7:0] ADDR_SCALE   = 8'h00;
  localparam logic [7:0] ADDR_RATE    = 8'h04;
  localparam logic [7:0] ADDR_VOLT    = 8'h08;
  localparam logic [7:0] ADDR_TRIM    = 8'h0c;
  localparam logic [7:0] ADDR_SLOT    = 8'h10;
  localparam logic [7:0] ADDR_CTRL    = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_APPLIED = 8'h1c;
  // Control register bit positions
  localparam int CTRL_DRY_RUN  = 0;
  localparam int CTRL_WELD_REQ = 1;
  localparam int CTRL_FWD_JOG  = 2;
  localparam int CTRL_REV_JOG  = 3;
  localparam int CTRL_OVERRIDE = 4;
  localparam int CTRL_W        = 5;
  // Set-point ranges in 0.1 units
  localparam logic [15:0] RATE_MIN      = 16'h000a;
  localparam logic [15:0] RATE_MAX      = 16'h00fa;
  localparam logic [15:0] VOLT_MIN      = 16'h0064;
  localparam logic [15:0] VOLT_MAX      = 16'h01e0;
  localparam logic [15:0] TRIM_MIN      = 16'h0000;
  localparam logic [15:0] TRIM_MAX_MIG  = 16'h00b4;
  localparam logic [15:0] TRIM_MAX_ALT  = 16'h0064;
  localparam logic [15:0] SCALE_OFF     = 16'h0000;
  localparam logic [15:0] DEC_FACTOR    = 16'h000a;
  localparam logic [7:0]  SLOT_MAX      = 8'h59;
  // Jog profile
  localparam logic [15:0] JOG_SLOW_RATE = 16'h000a;
  localparam logic [15:0] JOG_FAST_RATE = 16'h0032;
  localparam int          JOG_SLOW_MS   = 3000;
  localparam int          CLK_HZ        = 25000000;
  localparam int          JOG_SLOW_CYC  = (CLK_HZ / 1000) * JOG_SLOW_MS;
  // Weld process codes
  typedef enum logic [1:0] {
    RCD_PROC_MIG  = 2'h0,
    RCD_PROC_ALT1 = 2'h1,
    RCD_PROC_ALT2 = 2'h2
  } rcd_proc_type;
  // Sequencer states
  typedef enum logic [3:0] {
    RCD_IDLE = 4'b0001,
    RCD_WELD = 4'b0010,
    RCD_SIM  = 4'b0100,
    RCD_JOG  = 4'b1000
  } rcd_state_type;
  // Set-point bundle
  typedef struct packed {
    logic [15:0] rate;
    logic [15:0] volt;
    logic [15:0] trim;
  } rcd_sp_type;
  // Preset content from the preset store
  typedef struct packed {
    rcd_proc_type proc;
    rcd_sp_type   sp;
  } rcd_preset_type;
  // Motor and power command
  typedef struct packed {
    logic        power_on;
    logic        wire_run;
    logic        wire_reverse;
    logic [15:0] wire_rate;
  } rcd_drive_type;
endpackage

// File: core/rcd_robot_control_decoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Scale zero means raw unscaled values
// - Scaled value is max over scale times input
// - Division in tenths, extra digits truncated
// - Raw feeder rate accepted 10 to 250
// - Scaled feeder rate spans 0-25.0, floor 1.0
// - Raw voltage accepted 100 to 480
// - Scaled voltage spans 0-48.0, floor 10.0
// - Voltage for basic MIG, trim otherwise
// - Robot set-points override preset only when enabled
// - Basic MIG trim 0 to 180
// - Alternative processes trim 0 to 100
// - Scaled trim zero negative, scale positive end
// - Slot above 89 reads as 89
// - Slot change loads preset, even while welding
// - Dry run fakes arc and cycle, no power
// - Dry-run select frozen during weld or simulation
// - Request one starts sequence, zero ends it
// - Forward jog 1.0 for 3 s, then 5.0
// - Reverse jog same profile backwards
// - Jog ignored during real or simulated weld
module rcd_robot_control_decoder #(
  parameter int JOG_SLOW_CYCLES = rcd_pkg::JOG_SLOW_CYC,
  parameter int SP_W            = 16
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // Preset store
  output logic [7:0]                  preset_slot,
  output logic                        preset_load,
  input  wire rcd_pkg::rcd_preset_type preset_data,
  // Power stage feedback
  input  wire logic                   arc_sense,
  // Outputs to welder logic
  output rcd_pkg::rcd_sp_type         applied_sp,
  output logic                        volt_in_use,
  output rcd_pkg::rcd_drive_type      drive,
  output logic                        arc_established_flag,
  output logic                        cycle_active_flag
);
  import rcd_pkg::*;

  // Reset synchroniser
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Scaling: floor(max * 10 * v / scale) / 10, input capped at scale
  function automatic logic [15:0] scale_fn(input logic [15:0] max_v,
                                           input logic [15:0] in_v,
                                           input logic [15:0] scale);
    logic [15:0] v;
    logic [47:0] prod;
    logic [47:0] q;
    v    = (in_v > scale) ? scale : in_v;
    prod = 48'(max_v) * 48'(DEC_FACTOR) * 48'(v);
    q    = prod / 48'(scale);
    scale_fn = 16'(q / 48'(DEC_FACTOR));
  endfunction

  function automatic logic [15:0] clamp_fn(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    clamp_fn = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Read-back pads narrow fields with zeros
  function automatic logic [31:0] zext_fn(input logic [15:0] x);
    zext_fn = {16'h0000, x};
  endfunction

  // Status word: slot, latched dry-run, jog phase, process, one-hot state
  function automatic logic [31:0] status_fn(input logic [7:0]    slot,
                                            input logic          dry,
                                            input logic          fast,
                                            input rcd_proc_type  proc,
                                            input rcd_state_type st);
    status_fn = {16'h0000, slot, dry, fast, proc, st};
  endfunction

  function automatic logic wr_hit_fn(input logic       wr,
                                     input logic [7:0] addr,
                                     input logic [7:0] target);
    wr_hit_fn = wr && (addr == target);
  endfunction

  // Software registers
  logic [15:0]       scale_r;
  logic [15:0]       rate_in_r;
  logic [15:0]       volt_in_r;
  logic [15:0]       trim_in_r;
  logic [7:0]        slot_in_r;
  logic [CTRL_W-1:0] ctrl_r;

  // only the robot side writes these; one process per field
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scale_r <= SCALE_OFF;
    end else if (wr_hit_fn(reg_wr, reg_addr, ADDR_SCALE)) begin
      scale_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rate_in_r <= RATE_MIN;
    end else if (wr_hit_fn(reg_wr, reg_addr, ADDR_RATE)) begin
      rate_in_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      volt_in_r <= VOLT_MIN;
    end else if (wr_hit_fn(reg_wr, reg_addr, ADDR_VOLT)) begin
      volt_in_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      trim_in_r <= TRIM_MIN;
    end else if (wr_hit_fn(reg_wr, reg_addr, ADDR_TRIM)) begin
      trim_in_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      slot_in_r <= 8'h00;
    end else if (wr_hit_fn(reg_wr, reg_addr, ADDR_SLOT)) begin
      slot_in_r <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= '0;
    end else if (wr_hit_fn(reg_wr, reg_addr, ADDR_CTRL)) begin
      ctrl_r <= reg_wdata[CTRL_W-1:0];
    end
  end

  wire logic weld_req  = ctrl_r[CTRL_WELD_REQ];
  wire logic fwd_jog   = ctrl_r[CTRL_FWD_JOG];
  wire logic rev_jog   = ctrl_r[CTRL_REV_JOG];
  wire logic override  = ctrl_r[CTRL_OVERRIDE];

  // Preset slot select and load
  logic [7:0] slot_eff;
  logic       load_pend_r;
  assign slot_eff = (slot_in_r > SLOT_MAX) ? SLOT_MAX : slot_in_r;

  // A change is taken in any state, welding included
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      preset_slot <= 8'h00;
      preset_load <= 1'b0;
      load_pend_r <= 1'b1;
    end else begin
      preset_load <= 1'b0;
      // Back-to-back slot writes still give separate one-cycle pulses
      if ((slot_eff != preset_slot || load_pend_r) && !preset_load) begin
        preset_slot <= slot_eff;
        preset_load <= 1'b1;
        load_pend_r <= 1'b0;
      end
    end
  end

  // Store answers one cycle after the load pulse, so sample a cycle later
  logic load_ack_r;
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      load_ack_r <= 1'b0;
    end else begin
      load_ack_r <= preset_load;
    end
  end

  rcd_preset_type preset_r;
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      preset_r <= '0;
    end else if (load_ack_r) begin
      preset_r <= preset_data;
    end
  end

  // Set-point decode
  logic        scaled;
  logic        is_mig;
  logic [15:0] trim_max;
  rcd_sp_type  robot_sp;
  assign scaled   = (scale_r != SCALE_OFF);
  assign is_mig   = (preset_r.proc == RCD_PROC_MIG);
  assign trim_max = is_mig ? TRIM_MAX_MIG : TRIM_MAX_ALT;

  always_comb begin
    if (scaled) begin
      robot_sp.rate = clamp_fn(scale_fn(RATE_MAX, rate_in_r, scale_r),
                               RATE_MIN, RATE_MAX);
      robot_sp.volt = clamp_fn(scale_fn(VOLT_MAX, volt_in_r, scale_r),
                               VOLT_MIN, VOLT_MAX);
      // Zero maps to the negative end, scale to the positive end
      robot_sp.trim = clamp_fn(scale_fn(trim_max, trim_in_r, scale_r),
                               TRIM_MIN, trim_max);
    end else begin
      robot_sp.rate = clamp_fn(rate_in_r, RATE_MIN, RATE_MAX);
      robot_sp.volt = clamp_fn(volt_in_r, VOLT_MIN, VOLT_MAX);
      robot_sp.trim = clamp_fn(trim_in_r, TRIM_MIN, trim_max);
    end
  end

  // Registered so the wide divider stays off the output path
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      applied_sp  <= '0;
      volt_in_use <= 1'b1;
    end else begin
      applied_sp  <= override ? robot_sp : preset_r.sp;
      volt_in_use <= is_mig;
    end
  end

  // Sequencer
  rcd_state_type state_r;
  rcd_state_type state_nxt;
  logic          dry_run_r;
  logic          jog_rev_r;
  logic [31:0]   jog_cnt_r;
  logic          jog_fast;
  logic          weld_busy;
  logic          in_weld;
  logic          in_sim;
  logic          in_jog;
  logic          jog_req;
  logic          jog_hold;
  logic          dry_run_sel;
  assign weld_busy = (state_r == RCD_WELD) || (state_r == RCD_SIM);
  assign jog_fast  = (jog_cnt_r >= 32'(JOG_SLOW_CYCLES));
  assign in_weld   = (state_r == RCD_WELD);
  assign in_sim    = (state_r == RCD_SIM);
  assign in_jog    = (state_r == RCD_JOG);
  assign jog_req   = fwd_jog || rev_jog;
  assign jog_hold  = jog_rev_r ? rev_jog : fwd_jog;
  // Live select when idle, so one write may set the mode and the request together
  assign dry_run_sel = weld_busy ? dry_run_r : ctrl_r[CTRL_DRY_RUN];

  // Dry-run select only tracked outside a weld or simulation
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dry_run_r <= 1'b0;
    end else if (!weld_busy) begin
      dry_run_r <= ctrl_r[CTRL_DRY_RUN];
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RCD_IDLE: begin
        if (weld_req) begin
          state_nxt = dry_run_sel ? RCD_SIM : RCD_WELD;
        end else if (jog_req) begin
          state_nxt = RCD_JOG;
        end
      end
      RCD_WELD, RCD_SIM: begin
        if (!weld_req) begin
          state_nxt = RCD_IDLE;
        end
      end
      RCD_JOG: begin
        // Weld request takes precedence and ends the jog
        if (weld_req || !jog_hold) begin
          state_nxt = RCD_IDLE;
        end
      end
      default: state_nxt = RCD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= RCD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Jog direction latched at entry; forward wins if both are set
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      jog_rev_r <= 1'b0;
    end else if (state_r == RCD_IDLE) begin
      jog_rev_r <= !fwd_jog && rev_jog;
    end
  end

  // Slow-phase timer; saturates so the fast phase holds
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      jog_cnt_r <= '0;
    end else if (state_r != RCD_JOG) begin
      jog_cnt_r <= '0;
    end else if (!jog_fast) begin
      jog_cnt_r <= jog_cnt_r + 32'h00000001;
    end
  end

  // Drive outputs; power only in a real weld
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      drive <= '0;
    end else begin
      drive.power_on     <= in_weld;
      drive.wire_run     <= in_weld || in_jog;
      drive.wire_reverse <= in_jog && jog_rev_r;
      case (state_r)
        RCD_WELD: drive.wire_rate <= applied_sp.rate;
        RCD_JOG:  drive.wire_rate <= jog_fast ? JOG_FAST_RATE : JOG_SLOW_RATE;
        default:  drive.wire_rate <= '0;
      endcase
    end
  end

  // Status flags; a simulation raises both with no power behind them
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      arc_established_flag <= 1'b0;
      cycle_active_flag    <= 1'b0;
    end else begin
      arc_established_flag <= in_sim || (in_weld && arc_sense);
      cycle_active_flag    <= weld_busy;
    end
  end

  // Register read-back, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_SCALE:   reg_rdata <= zext_fn(scale_r);
        ADDR_RATE:    reg_rdata <= zext_fn(rate_in_r);
        ADDR_VOLT:    reg_rdata <= zext_fn(volt_in_r);
        ADDR_TRIM:    reg_rdata <= zext_fn(trim_in_r);
        ADDR_SLOT:    reg_rdata <= {24'h000000, slot_in_r};
        ADDR_CTRL:    reg_rdata <= {27'h0000000, ctrl_r};
        ADDR_STATUS:  reg_rdata <= status_fn(preset_slot, dry_run_r, jog_fast, preset_r.proc, state_r);
        ADDR_APPLIED: reg_rdata <= zext_fn(is_mig ? applied_sp.volt : applied_sp.trim);
        default:      reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// File: bench/rcd_robot_control_decoder_properties.sv
`timescale 1ns/1ps
module rcd_robot_control_decoder_properties #(
  parameter int JOG_SLOW_CYCLES = 20
) (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  // Register port
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  // Preset store
  input wire logic [7:0]             preset_slot,
  input wire logic                   preset_load,
  // Welder side
  input wire logic                   arc_sense,
  input wire rcd_pkg::rcd_drive_type drive,
  input wire logic                   arc_established_flag,
  input wire logic                   cycle_active_flag
);
  import rcd_pkg::*;
  logic [31:0] slow_cnt_r;
  logic        jog_slow;
  logic        jog_fast;
  assign jog_slow = drive.wire_run && !drive.power_on && drive.wire_rate == JOG_SLOW_RATE;
  assign jog_fast = drive.wire_run && !drive.power_on && drive.wire_rate == JOG_FAST_RATE;
  // Counts preceding slow jog cycles so the step moment is exact
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slow_cnt_r <= '0;
    end else begin
      slow_cnt_r <= jog_slow ? slow_cnt_r + 32'h1 : '0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_rdata_quiet; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data not idle");
  property p_slot_clamp; preset_slot <= SLOT_MAX; endproperty
  a_slot_clamp: assert property (p_slot_clamp) else $error("slot above limit");
  property p_load_pulse; preset_load |=> !preset_load; endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load not a pulse");
  property p_weld_drive; drive.power_on |-> drive.wire_run && !drive.wire_reverse && cycle_active_flag; endproperty
  a_weld_drive: assert property (p_weld_drive) else $error("weld drive wrong");
  property p_arc_follow; drive.power_on && $past(drive.power_on) |-> arc_established_flag == $past(arc_sense); endproperty
  a_arc_follow: assert property (p_arc_follow) else $error("arc flag wrong");
  property p_dry_run; cycle_active_flag && !drive.power_on |-> arc_established_flag && !drive.wire_run; endproperty
  a_dry_run: assert property (p_dry_run) else $error("dry run not faked");
  property p_jog_start; $rose(drive.wire_run) && !drive.power_on |-> jog_slow; endproperty
  a_jog_start: assert property (p_jog_start) else $error("jog not slow first");
  property p_jog_step; jog_fast && $past(jog_slow) |-> slow_cnt_r == JOG_SLOW_CYCLES; endproperty
  a_jog_step: assert property (p_jog_step) else $error("jog step time wrong");
  property p_jog_rates; drive.wire_run && !drive.power_on |-> jog_slow || jog_fast; endproperty
  a_jog_rates: assert property (p_jog_rates) else $error("jog rate wrong");
  property p_rev_idle; drive.wire_reverse |-> !drive.power_on && !cycle_active_flag; endproperty
  a_rev_idle: assert property (p_rev_idle) else $error("reverse during weld");
endmodule

// File: bench/rcd_preset_store.sv
`timescale 1ns/1ps
module rcd_preset_store (
  // Clock
  input wire logic            sys_clk,
  // Load request
  input wire logic [7:0]      preset_slot,
  input wire logic            preset_load,
  // Preset content
  output rcd_pkg::rcd_preset_type preset_data = '0
);
  import rcd_pkg::*;
  // Stale content is inverted each cycle so a sample one cycle late never matches
  always_ff @(posedge sys_clk) begin
    if (preset_load) begin
      preset_data <= {rcd_proc_type'(2'(preset_slot % 8'h03)), 16'h0014 + 16'(preset_slot),
                      16'h0096 + 16'(preset_slot), 8'h00, preset_slot};
    end else begin
      preset_data <= rcd_preset_type'(~preset_data);
    end
  end
endmodule

// File: bench/rcd_robot_control_decoder_tb.sv
`timescale 1ns/1ps
module rcd_robot_control_decoder_tb;
  import rcd_pkg::*;
  localparam int JOG = 20;
  logic           sys_clk   = 1'b0;
  logic           resetn    = 1'b0;
  logic [7:0]     reg_addr  = '0;
  logic [31:0]    reg_wdata = '0;
  logic           reg_wr    = 1'b0;
  logic           reg_rd    = 1'b0;
  logic           arc_sense = 1'b0;
  logic [31:0]    reg_rdata;
  logic [7:0]     preset_slot;
  logic           preset_load;
  logic           volt_in_use;
  logic           arc_established_flag;
  logic           cycle_active_flag;
  rcd_preset_type preset_data;
  rcd_sp_type     applied_sp;
  rcd_drive_type  drive;
  int             err_count = 0;
  int             n_tests   = 0;
  int             i, j, k;
  logic [31:0]    d;
  logic [15:0]    v, sc, ev, et;
  logic [7:0]     s;
  rcd_robot_control_decoder #(.JOG_SLOW_CYCLES(JOG)) i_rcd_robot_control_decoder (.sys_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .preset_slot, .preset_load, .preset_data, .arc_sense,
    .applied_sp, .volt_in_use, .drive, .arc_established_flag, .cycle_active_flag);
  rcd_preset_store i_rcd_preset_store (.sys_clk, .preset_slot, .preset_load, .preset_data);
  always #20 sys_clk = ~sys_clk;
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= x;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    x = reg_rdata;
  endtask
  function automatic logic [15:0] lim(logic [15:0] x, logic [15:0] lo, logic [15:0] hi);
    return (x < lo) ? lo : (x > hi) ? hi : x;
  endfunction
  // Scaled path works in tenths and truncates, like the robot side expects
  function automatic logic [15:0] want(logic [15:0] x, logic [15:0] c, logic [31:0] mx, logic [15:0] lo);
    logic [31:0] t;
    t = (x > c) ? 32'(c) : 32'(x);
    if (c == SCALE_OFF) return lim(x, lo, mx[15:0]);
    return lim(16'(mx * 32'(DEC_FACTOR) * t / 32'(c) / 32'(DEC_FACTOR)), lo, mx[15:0]);
  endfunction
  function automatic logic [47:0] preset_sp(logic [7:0] x);
    return {16'h0014 + 16'(x), 16'h0096 + 16'(x), 8'h00, x};
  endfunction
  task automatic summarize;
    $display("Errors %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
  initial begin
    void'($urandom(60006));
    cyc(4);
    chk(volt_in_use, 1'b1);
    chk(drive, '0);
    @(posedge sys_clk);
    resetn <= 1'b1;
    cyc(4);
    for (i = 0; i < 6; i++) begin
      s = (i < 3) ? 8'($urandom_range(255, 90)) : 8'($urandom_range(89, 0));
      s = (i == 0) ? SLOT_MAX + 8'h01 : (i == 3) ? SLOT_MAX : s;
      wr(ADDR_SLOT, 32'(s));
      cyc(5);
      s = (s > SLOT_MAX) ? SLOT_MAX : s;
      chk(preset_slot, s);
      chk(applied_sp, preset_sp(s));
      chk(volt_in_use, s % 8'h03 == 8'h00);
    end
    wr(ADDR_CTRL, 32'h10);
    for (k = 0; k < 2; k++) begin
      sc = k ? 16'h03ff : SCALE_OFF;
      wr(ADDR_SCALE, 32'(sc));
      for (i = 0; i < 2; i++) begin
        wr(ADDR_SLOT, 32'(i));
        for (j = 0; j < 4; j++) begin
          v = (j == 0) ? 16'h0 : (j == 1) ? (k ? 16'h0214 : 16'hffff) : 16'($urandom_range(1100, 0));
          wr(ADDR_RATE, 32'(v));
          wr(ADDR_VOLT, 32'(v));
          wr(ADDR_TRIM, 32'(v));
          cyc(3);
          ev = want(v, sc, 32'(VOLT_MAX), VOLT_MIN);
          et = want(v, sc, i ? 32'(TRIM_MAX_ALT) : 32'(TRIM_MAX_MIG), TRIM_MIN);
          chk(applied_sp.rate, want(v, sc, 32'(RATE_MAX), RATE_MIN));
          chk(applied_sp.volt, ev);
          chk(applied_sp.trim, et);
          rd(ADDR_APPLIED, d);
          chk(d, i ? et : ev);
          rd(ADDR_RATE, d);
          chk(d, v);
        end
      end
    end
    wr(ADDR_SCALE, 32'h0);
    wr(ADDR_RATE, 32'h64);
    wr(ADDR_CTRL, 32'h12);
    arc_sense <= 1'b1;
    cyc(4);
    chk(drive, {3'b110, 16'h0064});
    chk({cycle_active_flag, arc_established_flag}, 2'b11);
    wr(ADDR_CTRL, 32'h1f);
    wr(ADDR_SLOT, 32'h07);
    cyc(5);
    chk(drive, {3'b110, 16'h0064});
    chk(preset_slot, 8'h07);
    rd(ADDR_STATUS, d);
    chk(d[7], 1'b0);
    wr(ADDR_CTRL, 32'h11);
    cyc(4);
    chk({drive.power_on, cycle_active_flag}, 2'b00);
    wr(ADDR_CTRL, 32'h13);
    arc_sense <= 1'b0;
    cyc(4);
    chk({drive.power_on, drive.wire_run, cycle_active_flag, arc_established_flag}, 4'b0011);
    wr(ADDR_CTRL, 32'h1e);
    cyc(4);
    rd(ADDR_STATUS, d);
    chk({d[7:0], drive.wire_run}, {8'h94, 1'b0});
    wr(ADDR_CTRL, 32'h10);
    for (i = 0; i < 2; i++) begin
      wr(ADDR_CTRL, i ? 32'h18 : 32'h14);
      cyc(4);
      chk(drive, {2'b01, i[0], JOG_SLOW_RATE});
      cyc(JOG);
      chk(drive, {2'b01, i[0], JOG_FAST_RATE});
      wr(ADDR_CTRL, 32'h10);
      cyc(4);
      chk(drive.wire_run, 1'b0);
    end
    rd(8'h20, d);
    chk(d, '0);
    summarize();
  end
endmodule
bind rcd_robot_control_decoder rcd_robot_control_decoder_properties #(.JOG_SLOW_CYCLES(JOG_SLOW_CYCLES))
  i_rcd_robot_control_decoder_properties (.sys_clk, .resetn, .reg_rd, .reg_rdata, .preset_slot, .preset_load,
  .arc_sense, .drive, .arc_established_flag, .cycle_active_flag);
